//--- hw/nvs_pkg.sv
// Package of constants for the host-side shadowed memory controller
package nvs_pkg;
    localparam int ADDR_W = 13;                        // Address pins
    localparam int DATA_W = 8;                         // Data pins
    localparam logic [12:0] SEQ_A1 = 13'h0000;         // Sequence step one
    localparam logic [12:0] SEQ_A2 = 13'h1555;         // Sequence step two
    localparam logic [12:0] SEQ_A3 = 13'h0AAA;         // Sequence step three
    localparam logic [12:0] SEQ_A4 = 13'h1FFF;         // Sequence step four
    localparam logic [12:0] SEQ_A5 = 13'h10F0;         // Sequence step five
    localparam logic [12:0] SEQ_SAVE = 13'h0F0F;       // Sixth step, save
    localparam logic [12:0] SEQ_RESTORE = 13'h0F0E;    // Sixth step, restore
    localparam logic [2:0] SEQ_LAST = 3'h5;            // Index of the sixth step
    localparam int CLK_NS = 100;                       // Clock period in ns
    // Pin phase timing in ns (cycle figures derived, least times round up)
    localparam int SETUP_NS = 100;
    localparam int STROBE_NS = 200;
    localparam int HOLD_NS = 100;
    localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
    // Busy times of the device after save or restore, in ns
    localparam int SAVE_DURATION_NS = 10000000;
    localparam int RESTORE_DURATION_NS = 20000;
    localparam int SAVE_CYC = (SAVE_DURATION_NS + CLK_NS - 1) / CLK_NS;
    localparam int RESTORE_CYC = (RESTORE_DURATION_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 20;                         // Wait counter width
    // Host commands
    typedef enum logic [1:0] {
        NVS_OP_READ = 2'h0,
        NVS_OP_WRITE = 2'h1,
        NVS_OP_SAVE = 2'h2,
        NVS_OP_RESTORE = 2'h3
    } nvs_op_e;
endpackage : nvs_pkg

//--- hw/nvs_seq_rom.sv
// Address table of the six-read command sequence
`timescale 1ns/100ps
module nvs_seq_rom (
    input wire logic [2:0] step,
    input wire logic restore,
    output logic [12:0] addr
);
    ////////////////////////////////////////////////////////////////////////
    // Step lookup, last step chooses save or restore address
    always_comb begin
        case (step)
            3'h0: addr = nvs_pkg::SEQ_A1;
            3'h1: addr = nvs_pkg::SEQ_A2;
            3'h2: addr = nvs_pkg::SEQ_A3;
            3'h3: addr = nvs_pkg::SEQ_A4;
            3'h4: addr = nvs_pkg::SEQ_A5;
            default: addr = restore ? nvs_pkg::SEQ_RESTORE : nvs_pkg::SEQ_SAVE;
        endcase
    end
endmodule : nvs_seq_rom

//--- hw/nvs_host.sv
// Host controller driving an asynchronous shadowed static memory
`timescale 1ns/100ps
module nvs_host #(
    parameter int SAVE_WAIT = nvs_pkg::SAVE_CYC,       // Cycles of save busy
    parameter int RESTORE_WAIT = nvs_pkg::RESTORE_CYC  // Cycles of restore busy
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic req_valid,
    input wire nvs_pkg::nvs_op_e req_op,
    input wire logic [12:0] req_addr,
    input wire logic [7:0] req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_rdata,
    output logic [12:0] addr_pins,
    output logic chip_select_n,
    output logic write_strobe_n,
    output logic output_drive_n,
    input wire logic [7:0] data_pins_i,
    output logic [7:0] data_pins_o,
    output logic data_pins_oe
);
    ////////////////////////////////////////////////////////////////////////
    // Phase machine
    typedef enum logic [2:0] {
        NVS_IDLE = 3'b000,
        NVS_SETUP = 3'b001,
        NVS_STROBE = 3'b010,
        NVS_HOLD = 3'b011,
        NVS_BUSY = 3'b100
    } nvs_state_e;

    nvs_state_e state_q, state_d;      // Current phase
    logic [19:0] cnt_q, cnt_d;         // Phase and busy counter
    logic is_write_q, is_write_d;      // Access is a write
    logic is_seq_q, is_seq_d;          // Access is a sequence step
    logic restore_q, restore_d;        // Sequence ends in restore
    logic [2:0] step_q, step_d;        // Sequence step index
    logic [12:0] addr_q, addr_d;       // Address pins
    logic cs_n_q, cs_n_d;              // Select pin
    logic we_n_q, we_n_d;              // Strobe pin
    logic oe_n_q, oe_n_d;              // Output drive pin
    logic [7:0] wdat_q, wdat_d;        // Write data
    logic doe_q, doe_d;                // Data pin enable
    logic ready_q, ready_d;            // Request accepted when high
    logic rv_q, rv_d;                  // Answer pulse
    logic [7:0] rdat_q, rdat_d;        // Captured read data
    logic [7:0] din_s1_q, din_s2_q;    // Data pin synchroniser
    logic [12:0] seq_addr;             // Address of next step

    // Sequence address lookup
    // Looks one step ahead so the next address is ready as a step ends
    nvs_seq_rom u_rom (
        .step(step_q + 3'h1),
        .restore(restore_q),
        .addr(seq_addr)
    );

    // Count of cycles, cut to counter width
    function automatic logic [19:0] cyc(input int n);
        cyc = 20'(n);
    endfunction : cyc

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        is_write_d = is_write_q;
        is_seq_d = is_seq_q;
        restore_d = restore_q;
        step_d = step_q;
        addr_d = addr_q;
        cs_n_d = cs_n_q;
        we_n_d = we_n_q;
        oe_n_d = oe_n_q;
        wdat_d = wdat_q;
        doe_d = doe_q;
        ready_d = ready_q;
        rv_d = 1'b0;
        rdat_d = rdat_q;
        case (state_q)
            NVS_IDLE: begin
                // Accept one request; select, strobe and output drive pins idle high
                if (req_valid && ready_q) begin
                    ready_d = 1'b0;
                    cnt_d = cyc(nvs_pkg::SETUP_CYC);
                    state_d = NVS_SETUP;
                    is_write_d = (req_op == nvs_pkg::NVS_OP_WRITE);
                    is_seq_d = (req_op == nvs_pkg::NVS_OP_SAVE) || (req_op == nvs_pkg::NVS_OP_RESTORE);
                    restore_d = (req_op == nvs_pkg::NVS_OP_RESTORE);
                    step_d = 3'h0;
                    wdat_d = req_wdata;
                    addr_d = is_seq_d ? nvs_pkg::SEQ_A1 : req_addr;
                end
            end
            NVS_SETUP: begin
                if (cnt_q <= 20'h00001) begin
                    cs_n_d = 1'b0;
                    cnt_d = cyc(nvs_pkg::STROBE_CYC);
                    state_d = NVS_STROBE;
                    if (is_write_q) begin
                        we_n_d = 1'b0;
                        doe_d = 1'b1;
                    end else if (!is_seq_q) begin
                        oe_n_d = 1'b0;
                    end
                end else begin
                    cnt_d = cnt_q - 20'h00001;
                end
            end
            NVS_STROBE: begin
                if (cnt_q <= 20'h00001) begin
                    // Controls rise together; the byte is still in the synchroniser
                    cs_n_d = 1'b1;
                    we_n_d = 1'b1;
                    oe_n_d = 1'b1;
                    cnt_d = cyc(nvs_pkg::HOLD_CYC);
                    state_d = NVS_HOLD;
                end else begin
                    cnt_d = cnt_q - 20'h00001;
                end
            end
            NVS_HOLD: begin
                if (cnt_q <= 20'h00001) begin
                    doe_d = 1'b0;
                    if (is_seq_q && step_q != nvs_pkg::SEQ_LAST) begin
                        step_d = step_q + 3'h1;
                        addr_d = seq_addr;
                        cnt_d = cyc(nvs_pkg::SETUP_CYC);
                        state_d = NVS_SETUP;
                    end else if (is_seq_q) begin
                        // wait out the save or restore busy time
                        cnt_d = restore_q ? cyc(RESTORE_WAIT) : cyc(SAVE_WAIT);
                        state_d = NVS_BUSY;
                    end else begin
                        // two-flop lag shows the byte seen before the rise
                        if (!is_write_q) begin
                            rdat_d = din_s2_q;
                        end
                        rv_d = 1'b1;
                        ready_d = 1'b1;
                        state_d = NVS_IDLE;
                    end
                end else begin
                    cnt_d = cnt_q - 20'h00001;
                end
            end
            NVS_BUSY: begin
                if (cnt_q <= 20'h00001) begin
                    rv_d = 1'b1;
                    ready_d = 1'b1;
                    is_seq_d = 1'b0;
                    state_d = NVS_IDLE;
                end else begin
                    cnt_d = cnt_q - 20'h00001;
                end
            end
            default: begin
                state_d = NVS_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State registers; clock enable freezes everything
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_q <= NVS_IDLE;
            cnt_q <= 20'h00000;
            is_write_q <= 1'b0;
            is_seq_q <= 1'b0;
            restore_q <= 1'b0;
            step_q <= 3'h0;
            addr_q <= 13'h0000;
            cs_n_q <= 1'b1;
            we_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            wdat_q <= 8'h00;
            doe_q <= 1'b0;
            ready_q <= 1'b1;
            rv_q <= 1'b0;
            rdat_q <= 8'h00;
            din_s1_q <= 8'h00;
            din_s2_q <= 8'h00;
        end else if (clk_en) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            is_write_q <= is_write_d;
            is_seq_q <= is_seq_d;
            restore_q <= restore_d;
            step_q <= step_d;
            addr_q <= addr_d;
            cs_n_q <= cs_n_d;
            we_n_q <= we_n_d;
            oe_n_q <= oe_n_d;
            wdat_q <= wdat_d;
            doe_q <= doe_d;
            ready_q <= ready_d;
            rv_q <= rv_d;
            rdat_q <= rdat_d;
            // Pins come from outside the clock domain
            din_s1_q <= data_pins_i;
            din_s2_q <= din_s1_q;
        end
    end

    // Outputs straight from flip-flops
    assign req_ready = ready_q;
    assign rsp_valid = rv_q;
    assign rsp_rdata = rdat_q;
    assign addr_pins = addr_q;
    assign chip_select_n = cs_n_q;
    assign write_strobe_n = we_n_q;
    assign output_drive_n = oe_n_q;
    assign data_pins_o = wdat_q;
    assign data_pins_oe = doe_q;
endmodule : nvs_host

//--- testbench/nvs_host_checker.sv
// Pin checker bound to the shadowed memory host
`timescale 1ns/100ps
module nvs_host_checker (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic req_valid,
    input wire nvs_pkg::nvs_op_e req_op,
    input wire logic [12:0] req_addr,
    input wire logic [7:0] req_wdata,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic [12:0] addr_pins,
    input wire logic chip_select_n,
    input wire logic write_strobe_n,
    input wire logic output_drive_n,
    input wire logic [7:0] data_pins_o,
    input wire logic data_pins_oe
);
    ////////////////////////////////////////////////////////////
    logic take; // Request taken this edge
    logic seq_q, rest_q; // In a sequence; it ends in restore
    logic [2:0] step_q; // Selects seen so far
    logic [12:0] exp_a [6]; // Sequence order, save ending
    assign take = clk_en && req_valid && req_ready;
    assign exp_a = '{13'h0000, 13'h1555, 13'h0AAA, 13'h1FFF, 13'h10F0, 13'h0F0F};
    // Count selects; a take at the done edge starts afresh
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            seq_q <= 1'b0;
            rest_q <= 1'b0;
            step_q <= 3'h0;
        end else if (take) begin
            seq_q <= req_op[1];
            rest_q <= req_op[0];
            step_q <= 3'h0;
        end else if (rsp_valid) begin
            seq_q <= 1'b0;
        end else if (seq_q && $fell(chip_select_n)) begin
            step_q <= step_q + 3'h1;
        end
    end
    // Frozen clock enable stretches timing, so checks pause
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst || !clk_en);
    a_write_addr_hold: assert property ((!chip_select_n && !write_strobe_n) |=> $stable(addr_pins))
        else $error("address moved in write");
    a_write_oe_high: assert property (!write_strobe_n |-> output_drive_n && data_pins_oe)
        else $error("output drive low in write");
    a_write_release: assert property ($rose(write_strobe_n) |=> !data_pins_oe)
        else $error("data held after write");
    a_seq_no_write: assert property (seq_q |-> write_strobe_n && output_drive_n && !data_pins_oe)
        else $error("strobe or drive in sequence");
    a_seq_addr_order: assert property (seq_q && $fell(chip_select_n) |->
        addr_pins == ((rest_q && step_q == 3'h5) ? 13'h0F0E : exp_a[step_q]))
        else $error("sequence address wrong");
    a_seq_six_reads: assert property (seq_q && rsp_valid |-> step_q == 3'h6)
        else $error("sequence not six reads");
    a_read_walk: assert property (take && req_op == nvs_pkg::NVS_OP_READ |=> ##1
        (!chip_select_n && !output_drive_n && write_strobe_n && addr_pins == $past(req_addr, 2))[*2]
        ##1 chip_select_n ##1 rsp_valid)
        else $error("read cycle shape wrong");
    a_write_walk: assert property (take && req_op == nvs_pkg::NVS_OP_WRITE |=> ##1
        (!chip_select_n && !write_strobe_n && data_pins_o == $past(req_wdata, 2) && addr_pins == $past(req_addr, 2))
        ##1 (!chip_select_n && $stable(data_pins_o)) ##1 (chip_select_n && write_strobe_n) ##1 rsp_valid)
        else $error("write cycle shape wrong");
endmodule : nvs_host_checker
bind nvs_host nvs_host_checker chk_u (.sys_clk, .sys_rst, .clk_en, .req_valid, .req_op, .req_addr, .req_wdata,
    .req_ready, .rsp_valid, .addr_pins, .chip_select_n, .write_strobe_n, .output_drive_n, .data_pins_o, .data_pins_oe);

//--- testbench/nvs_mem_model.sv
// Behavioural shadowed static memory at the host's far side
`timescale 1ns/100ps
module nvs_mem_model #(
    parameter int SAVE_NS = 800, // Busy after save
    parameter int RESTORE_NS = 300 // Busy after restore
) (
    input wire logic [12:0] addr_pins,
    input wire logic chip_select_n,
    input wire logic write_strobe_n,
    input wire logic output_drive_n,
    input wire logic [7:0] data_pins_o,
    input wire logic data_pins_oe,
    output logic [7:0] data_lvl
);
    ////////////////////////////////////////////////////////////
    logic [7:0] mem_a [8192]; // Volatile bytes, unknown at start
    logic [7:0] shadow_a [8192]; // Shadow copy
    logic [7:0] last_v = 8'h00; // Last driven level
    logic busy = 1'b0, wr_seen = 1'b0, dev_on, wr;
    logic [2:0] step = 3'h0; // Sequence steps matched
    logic [12:0] seq_a [5] = '{13'h0000, 13'h1555, 13'h0AAA, 13'h1FFF, 13'h10F0};
    assign dev_on = !busy && !chip_select_n && !output_drive_n && write_strobe_n;
    assign wr = !chip_select_n && !write_strobe_n;
    // data follows address; a free wire shows the inverse
    assign data_lvl = data_pins_oe ? data_pins_o : (dev_on ? mem_a[addr_pins] : ~last_v);
    always @(data_lvl) if (data_pins_oe || dev_on) last_v = data_lvl;
    always @(posedge wr) wr_seen = 1'b1;
    // Each access ends at select rise; busy time blocks it (deaf)
    always @(posedge chip_select_n) begin
        if (wr_seen) begin
            mem_a[addr_pins] = data_lvl;
            step = 3'h0;
        end else if (step == 3'h5 && (addr_pins == 13'h0F0F || addr_pins == 13'h0F0E)) begin
            step = 3'h0;
            busy = 1'b1;
            if (addr_pins == 13'h0F0F) begin
                shadow_a = '{default: 8'hFF};
                shadow_a = mem_a;
                #(SAVE_NS);
            end else begin
                mem_a = '{default: 8'h00};
                mem_a = shadow_a;
                #(RESTORE_NS);
            end
            busy = 1'b0;
        end else begin
            step = (step < 3'h5 && addr_pins == seq_a[step]) ? step + 3'h1 : {2'b0, addr_pins == 13'h0000};
        end
        wr_seen = 1'b0;
    end
endmodule : nvs_mem_model

//--- testbench/nvs_host_bench.sv
// Self-checking bench of the shadowed memory host
`timescale 1ns/100ps
module nvs_host_bench;
    logic sys_clk, sys_rst, clk_en, req_valid, req_ready, rsp_valid;
    nvs_pkg::nvs_op_e req_op;
    logic [12:0] req_addr, addr_pins;
    logic [7:0] req_wdata, rsp_rdata, data_pins_o, data_pins_i;
    logic chip_select_n, write_strobe_n, output_drive_n, data_pins_oe;
    int n_errors = 0, checks_done = 0, cycles = 0;
    ////////////////////////////////////////////////////////////
    // Short busy waits keep the run brief
    nvs_host #(.SAVE_WAIT(10), .RESTORE_WAIT(5)) dut_u (.sys_clk, .sys_rst, .clk_en, .req_valid, .req_op,
        .req_addr, .req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .addr_pins, .chip_select_n, .write_strobe_n,
        .output_drive_n, .data_pins_i, .data_pins_o, .data_pins_oe);
    nvs_mem_model #(.SAVE_NS(800), .RESTORE_NS(300)) mem_u (.addr_pins, .chip_select_n, .write_strobe_n,
        .output_drive_n, .data_pins_o, .data_pins_oe, .data_lvl(data_pins_i));
    // Clock and hang guard
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            n_errors++;
            final_report();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] expd);
        checks_done++;
        if (seen !== expd) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, expd);
        end
    endtask : check
    // One request; waits for the done pulse, compares read data
    task automatic acc(input nvs_pkg::nvs_op_e op, input logic [12:0] a, input logic [7:0] d);
        int n;
        @(negedge sys_clk);
        while (req_ready !== 1'b1) @(negedge sys_clk);
        req_valid = 1'b1;
        req_op = op;
        req_addr = a;
        req_wdata = d;
        @(negedge sys_clk);
        req_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 200) begin
            @(negedge sys_clk);
            n++;
        end
        check({7'h0, rsp_valid}, 8'h01);
        check({7'h0, req_ready}, 8'h01);
        if (op == nvs_pkg::NVS_OP_READ) check(rsp_rdata, d);
    endtask : acc
    task automatic test_rw();
        logic [12:0] a [3] = '{13'h0000, 13'h1FFF, 13'h0AAA};
        logic [7:0] d [3] = '{8'hA5, 8'h5A, 8'h3C};
        for (int i = 0; i < 3; i++) acc(nvs_pkg::NVS_OP_WRITE, a[i], d[i]);
        for (int i = 0; i < 3; i++) acc(nvs_pkg::NVS_OP_READ, a[i], d[i]);
        $display("test_rw done");
    endtask : test_rw
    task automatic test_nv();
        acc(nvs_pkg::NVS_OP_WRITE, 13'h0123, 8'hC3);
        acc(nvs_pkg::NVS_OP_READ, 13'h0000, 8'hA5);
        acc(nvs_pkg::NVS_OP_SAVE, 13'h0000, 8'h00);
        acc(nvs_pkg::NVS_OP_WRITE, 13'h0123, 8'h00);
        acc(nvs_pkg::NVS_OP_READ, 13'h0123, 8'h00);
        acc(nvs_pkg::NVS_OP_RESTORE, 13'h0000, 8'h00);
        acc(nvs_pkg::NVS_OP_READ, 13'h0123, 8'hC3);
        acc(nvs_pkg::NVS_OP_WRITE, 13'h0123, 8'h11);
        acc(nvs_pkg::NVS_OP_RESTORE, 13'h0000, 8'h00);
        acc(nvs_pkg::NVS_OP_READ, 13'h0123, 8'hC3);
        acc(nvs_pkg::NVS_OP_READ, 13'h1FFF, 8'h5A);
        $display("test_nv done");
    endtask : test_nv
    // Freeze the clock enable mid-read: pins must hold, the read must still finish
    task automatic test_hold();
        acc(nvs_pkg::NVS_OP_WRITE, 13'h0055, 8'h96);
        @(negedge sys_clk);
        req_valid = 1'b1;
        req_op = nvs_pkg::NVS_OP_READ;
        req_addr = 13'h0055;
        @(negedge sys_clk);
        req_valid = 1'b0;
        @(negedge sys_clk);
        clk_en = 1'b0;
        repeat (4) @(negedge sys_clk);
        check({7'h0, chip_select_n}, 8'h00);
        check({7'h0, output_drive_n}, 8'h00);
        clk_en = 1'b1;
        repeat (3) @(negedge sys_clk);
        check({7'h0, rsp_valid}, 8'h01);
        check(rsp_rdata, 8'h96);
        $display("test_hold done");
    endtask : test_hold
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report
    // Reset for ten cycles, then the tests
    initial begin
        sys_rst = 1'b1;
        clk_en = 1'b1;
        req_valid = 1'b0;
        req_op = nvs_pkg::NVS_OP_READ;
        req_addr = 13'h0000;
        req_wdata = 8'h00;
        repeat (10) @(negedge sys_clk);
        sys_rst = 1'b0;
        test_rw();
        test_nv();
        test_hold();
        final_report();
    end
endmodule : nvs_host_bench
